// ==== inc/eeprom_cfg.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the EEPROM
 * access block. Assumes a 40 MHz core clock and a 12-bit AXI4-Lite address.
 */
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define NVM_CTRL_OFF 12'h000
`define IRQ_STATUS_OFF 12'h004
`define IRQ_MASK_OFF 12'h008
`define CTRL_RESET 1'b0
`define MAP_EN_BIT 1
`define BUSY_BIT 0
`define LAUNCH_LSB 4
`define LAUNCH_MSB 7
`define LAUNCH_FIRST 4'h5
`define LAUNCH_SECOND 4'hA
`define ARRAY_TOP 16'h07FF
`define PAGE_LSB 7
`define PAGE_MSB 10
`define IRQ_DONE_BIT 0
`define IRQ_ABORT_BIT 1
`define IRQ_RESET 2'h0
`define ERASED_BYTE 8'hFF
`define REFUSED_BYTE 8'hFF
`define PROG_TIME_NS 100000
`define CLK_PERIOD_NS 25
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== inc/eeprom_pkg.sv ====
/*
 * Types and shared decode for the EEPROM access block.
 * Assumes eeprom_cfg.svh is on the include path.
 */
`include "eeprom_cfg.svh"
package eeprom_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_WAIT} prog_state_e;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] col_t;
    typedef logic [3:0] page_t;
    typedef logic [10:0] addr_t;
    typedef logic [11:0] timer_t;

    // External address falls inside the array window
    function automatic logic in_array(input logic [15:0] a);
        return a <= `ARRAY_TOP;
    endfunction
endpackage

// ==== inc/latch_if.sv ====
/*
 * Link between the access controller and the column latch bank.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface latch_if;
    logic load;
    logic [6:0] load_col;
    logic [7:0] load_data;
    logic clear_all;
    logic [6:0] rd_col;
    logic [7:0] rd_data;
    logic rd_flag;
    logic any_flag;
    modport ctrl (output load, load_col, load_data, clear_all, rd_col,
                  input rd_data, rd_flag, any_flag);
    modport latch (input load, load_col, load_data, clear_all, rd_col,
                   output rd_data, rd_flag, any_flag);
endinterface

// ==== design/col_latch.sv ====
/*
 * Column latch bank: 128 data bytes, each with a written flag.
 * Assumes synchronous active-high reset.
 */
`timescale 1ns/1ps
module col_latch (
    input wire logic clock,
    input wire logic rst,
    latch_if.latch lif
);
    logic [7:0] data_q [128];
    logic [127:0] flag_q;

    always_ff @(posedge clock) begin
        if (lif.load) begin
            data_q[lif.load_col] <= lif.load_data;
        end
    end

    // A load in the clearing cycle keeps its flag
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            if (lif.clear_all) begin
                flag_q <= '0;
            end
            if (lif.load) begin
                flag_q[lif.load_col] <= 1'b1;
            end
        end
    end

    assign lif.rd_data = data_q[lif.rd_col];
    assign lif.rd_flag = flag_q[lif.rd_col];
    assign lif.any_flag = |flag_q;
endmodule

// ==== design/eeprom_array.sv ====
/*
 * 2-Kbyte nonvolatile array model in flip-flops, one write port.
 * Assumes synchronous active-high reset restores the erased state.
 */
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_array (
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [10:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [10:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [2048];

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 2048; i++) begin
                mem_q[i] <= `ERASED_BYTE;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_q[rd_addr];
endmodule

// ==== design/eeprom_page_write_access.sv ====
/*
 * EEPROM page-write access: external data port from the CPU, AXI4-Lite
 * control registers, column latches, programming sequencer, interrupt.
 * Assumes one clock, synchronous active-high reset, and a CPU that holds
 * an external data request until it sees the acknowledge.
 */
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_page_write_access (
    input wire logic clock,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU external data move port
    input wire logic xd_req,
    input wire logic xd_write,
    input wire logic [15:0] xd_addr,
    input wire logic [7:0] xd_wdata,
    output logic xd_ack,
    output logic [7:0] xd_rdata,
    output logic xd_to_ram,
    output logic xd_refused,
    // CPU finished an instruction other than a control register write
    input wire logic insn_step,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////
    latch_if lif ();

    logic awready_q;
    logic wready_q;
    logic arready_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_do;
    logic ctrl_wr;
    logic [3:0] launch_code;

    logic map_en_q;
    logic armed_q;
    logic busy_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic irq_q;
    logic abort_evt;
    logic start_evt;
    logic done_evt;

    eeprom_pkg::prog_state_e state_q;
    eeprom_pkg::col_t idx_q;
    eeprom_pkg::timer_t timer_q;
    eeprom_pkg::page_t page_q;

    logic xd_take;
    logic xd_mapped;
    logic xd_ack_q;
    logic [7:0] xd_rdata_q;
    logic xd_to_ram_q;
    logic xd_refused_q;
    logic page_ok;
    logic arr_wr_en;
    logic [10:0] arr_wr_addr;
    logic [7:0] arr_rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    ////////////////////////////////////////////////////////////////////////
    col_latch u_latch (
        .clock(clock),
        .rst(rst),
        .lif(lif)
    );

    eeprom_array u_array (
        .clock(clock),
        .rst(rst),
        .wr_en(arr_wr_en),
        .wr_addr(arr_wr_addr),
        .wr_data(lif.rd_data),
        .rd_addr(xd_addr[10:0]),
        .rd_data(arr_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            awready_q <= 1'b0;
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else begin
            awready_q <= !awready_q && s_axi_awvalid && !aw_hold_q && !bvalid_q;
            if (awready_q && s_axi_awvalid) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wready_q <= 1'b0;
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            wready_q <= !wready_q && s_axi_wvalid && !w_hold_q && !bvalid_q;
            if (wready_q && s_axi_wvalid) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_do) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    assign wr_do = aw_hold_q && w_hold_q && !bvalid_q;
    assign ctrl_wr = wr_do && wstrb_q[0] && awaddr_q == `NVM_CTRL_OFF;
    assign launch_code = wdata_q[`LAUNCH_MSB:`LAUNCH_LSB];

    always_ff @(posedge clock) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == `NVM_CTRL_OFF || awaddr_q == `IRQ_STATUS_OFF ||
                        awaddr_q == `IRQ_MASK_OFF) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            arready_q <= 1'b0;
        end else begin
            arready_q <= !arready_q && s_axi_arvalid && !rvalid_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else if (arready_q && s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            rresp_q <= `RESP_OKAY;
            rdata_q <= '0;
            unique case (s_axi_araddr)
                `NVM_CTRL_OFF: begin
                    rdata_q[`MAP_EN_BIT] <= map_en_q;
                    rdata_q[`BUSY_BIT] <= busy_q;
                end
                `IRQ_STATUS_OFF: rdata_q[1:0] <= irq_status_q;
                `IRQ_MASK_OFF: rdata_q[1:0] <= irq_mask_q;
                default: rresp_q <= `RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and launch sequence
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            map_en_q <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            map_en_q <= wdata_q[`MAP_EN_BIT];
        end
    end

    // Second code must be the very next action after the first
    assign start_evt = armed_q && ctrl_wr && launch_code == `LAUNCH_SECOND &&
                       state_q == eeprom_pkg::ST_IDLE;
    assign abort_evt = armed_q && !start_evt &&
                       (wr_do || insn_step || xd_take);

    always_ff @(posedge clock) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (ctrl_wr && launch_code == `LAUNCH_FIRST && !busy_q) begin
            armed_q <= 1'b1;
        end else if (start_evt || abort_evt) begin
            armed_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming sequencer
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= eeprom_pkg::ST_IDLE;
            idx_q <= '0;
            timer_q <= '0;
        end else begin
            unique case (state_q)
                eeprom_pkg::ST_IDLE: begin
                    idx_q <= '0;
                    timer_q <= '0;
                    if (start_evt) begin
                        state_q <= eeprom_pkg::ST_COPY;
                    end
                end
                eeprom_pkg::ST_COPY: begin
                    idx_q <= idx_q + 7'd1;
                    if (idx_q == 7'h7F) begin
                        state_q <= eeprom_pkg::ST_WAIT;
                    end
                end
                eeprom_pkg::ST_WAIT: begin
                    timer_q <= timer_q + 12'd1;
                    if (timer_q == 12'(`PROG_CYCLES - 1)) begin
                        state_q <= eeprom_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign done_evt = state_q == eeprom_pkg::ST_WAIT &&
                      timer_q == 12'(`PROG_CYCLES - 1);

    always_ff @(posedge clock) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (start_evt) begin
            busy_q <= 1'b1;
        end else if (done_evt) begin
            busy_q <= 1'b0;
        end
    end

    // Copy walks all columns; only flagged bytes reach the row
    assign arr_wr_en = state_q == eeprom_pkg::ST_COPY && lif.rd_flag;
    assign arr_wr_addr = {page_q, idx_q};

    ////////////////////////////////////////////////////////////////////////
    // External data port
    ////////////////////////////////////////////////////////////////////////
    assign xd_take = xd_req && !xd_ack_q;
    assign xd_mapped = map_en_q && eeprom_pkg::in_array(xd_addr);
    // First page loaded since the last run owns the latches
    assign page_ok = !lif.any_flag ||
                     xd_addr[`PAGE_MSB:`PAGE_LSB] == page_q;

    always_comb begin
        lif.load = xd_take && xd_write && xd_mapped && !busy_q && page_ok;
        lif.load_col = xd_addr[6:0];
        lif.load_data = xd_wdata;
        lif.clear_all = done_evt;
        lif.rd_col = idx_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            page_q <= '0;
        end else if (lif.load && !lif.any_flag) begin
            page_q <= xd_addr[`PAGE_MSB:`PAGE_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            xd_ack_q <= 1'b0;
            xd_rdata_q <= '0;
            xd_to_ram_q <= 1'b0;
            xd_refused_q <= 1'b0;
        end else begin
            xd_ack_q <= xd_take;
            xd_to_ram_q <= xd_take && !xd_mapped;
            xd_refused_q <= xd_take && xd_mapped && busy_q;
            if (xd_take && !xd_write) begin
                if (!xd_mapped) begin
                    xd_rdata_q <= '0;
                end else if (busy_q) begin
                    xd_rdata_q <= `REFUSED_BYTE;
                end else begin
                    xd_rdata_q <= arr_rd_data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_status_q <= `IRQ_RESET;
        end else begin
            if (wr_do && wstrb_q[0] && awaddr_q == `IRQ_STATUS_OFF) begin
                irq_status_q <= irq_status_q & ~wdata_q[1:0];
            end
            if (done_evt) begin
                irq_status_q[`IRQ_DONE_BIT] <= 1'b1;
            end
            if (abort_evt) begin
                irq_status_q[`IRQ_ABORT_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_mask_q <= `IRQ_RESET;
        end else if (wr_do && wstrb_q[0] && awaddr_q == `IRQ_MASK_OFF) begin
            irq_mask_q <= wdata_q[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign xd_ack = xd_ack_q;
    assign xd_rdata = xd_rdata_q;
    assign xd_to_ram = xd_to_ram_q;
    assign xd_refused = xd_refused_q;
    assign irq = irq_q;
endmodule

// ==== tb/eeprom_access_properties.sv ====
/*
 * Port checker for the EEPROM access block: external data port answers
 * and AXI4-Lite handshakes. Assumes eeprom_cfg.svh on the include path.
 */
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_access_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic xd_req,
    input wire logic xd_write,
    input wire logic [15:0] xd_addr,
    input wire logic xd_ack,
    input wire logic [7:0] xd_rdata,
    input wire logic xd_to_ram,
    input wire logic xd_refused,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    property p_xd_answer;
        xd_req && !xd_ack |=> xd_ack ##1 !xd_ack;
    endproperty
    a_xd_answer: assert property (p_xd_answer) else $error("no single ack");
    property p_ack_cause;
        xd_ack |-> $past(xd_req) && !$past(xd_ack);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without take");
    property p_outside_ram;
        xd_req && !xd_ack && xd_addr > `ARRAY_TOP |=> xd_to_ram && !xd_refused;
    endproperty
    a_outside_ram: assert property (p_outside_ram) else $error("high address");
    property p_ram_read_zero;
        xd_ack && xd_to_ram && !$past(xd_write) |-> xd_rdata == 8'h00;
    endproperty
    a_ram_read_zero: assert property (p_ram_read_zero) else $error("ram data");
    property p_refused_ff;
        xd_ack && xd_refused && !$past(xd_write) |-> xd_rdata == `REFUSED_BYTE;
    endproperty
    a_refused_ff: assert property (p_refused_ff) else $error("refused data");
    property p_flags_with_ack;
        xd_to_ram || xd_refused |-> xd_ack && !(xd_to_ram && xd_refused);
    endproperty
    a_flags_with_ack: assert property (p_flags_with_ack) else $error("stray flag");
    property p_write_answer;
        s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("late bvalid");
    property p_resp_stands;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_resp_stands: assert property (p_resp_stands) else $error("bresp moved");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("late rvalid");
endmodule
bind eeprom_page_write_access eeprom_access_properties props_u (.*);

// ==== tb/cpu_core_model.sv ====
/*
 * CPU core model: issues external data moves and other instructions.
 * Assumes the block acks once per take; released lines show inverted data.
 */
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic clock,
    input wire logic xd_ack,
    input wire logic [7:0] xd_rdata,
    input wire logic xd_to_ram,
    input wire logic xd_refused,
    output logic xd_req,
    output logic xd_write,
    output logic [15:0] xd_addr,
    output logic [7:0] xd_wdata,
    output logic insn_step
);
    initial begin
        xd_req = 1'b0;
        xd_write = 1'b0;
        xd_addr = 16'hA5A5;
        xd_wdata = 8'h5A;
        insn_step = 1'b0;
    end
    // Gap plus one idle cycles before each request model a slow core
    task automatic move(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        input int gap, output logic [7:0] rd, output logic ram,
                        output logic rf, output logic ok);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge clock);
        xd_req <= 1'b1;
        xd_write <= wr;
        xd_addr <= a;
        xd_wdata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (xd_ack !== 1'b1 && n < 20);
        ok = (xd_ack === 1'b1);
        rd = xd_rdata;
        ram = xd_to_ram;
        rf = xd_refused;
        xd_req <= 1'b0;
        xd_write <= ~wr;
        xd_addr <= ~a;
        xd_wdata <= ~d;
    endtask
    task automatic step();
        @(posedge clock);
        insn_step <= 1'b1;
        @(posedge clock);
        insn_step <= 1'b0;
    endtask
endmodule

// ==== tb/eeprom_page_write_access_test.sv ====
/*
 * Self-checking bench: AXI4-Lite register tasks and a CPU core model.
 * Assumes design, package and checker files are compiled first.
 */
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_page_write_access_test;
    logic clock, rst, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic xd_req, xd_write, xd_ack, xd_to_ram, xd_refused, insn_step;
    logic [15:0] xd_addr;
    logic [7:0] xd_wdata, xd_rdata;
    logic [15:0] la[4] = '{16'h0180, 16'h01FF, 16'h0185, 16'h0201};
    logic [7:0] ld[4] = '{8'h3C, 8'hC3, 8'h5A, 8'h11};
    logic [7:0] le[4] = '{8'h3C, 8'hC3, 8'h5A, 8'hFF};
    int error_cnt = 0;
    int samples_checked = 0;
    eeprom_page_write_access dut_u (.*);
    cpu_core_model cpu_u (.*);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic fail_wait();
        error_cnt++;
        $display("unexpected at %0t: wait ran out", $time);
        give_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clock);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 20);
        rd = s_axi_rdata;
        resp = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1) fail_wait();
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [31:0] r;
        logic [1:0] resp;
        axi(1'b1, a, d, r, resp);
        chk({30'h0, resp}, {30'h0, er});
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] r;
        logic [1:0] resp;
        axi(1'b0, a, 32'h0, r, resp);
        chk({r[29:0], resp}, {e[29:0], er});
    endtask
    // Flags are {to_ram, refused}
    task automatic xd(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] er, input logic [1:0] ef);
        logic [7:0] rd;
        logic ram, rf, ok;
        cpu_u.move(wr, a, d, int'(a[1:0]), rd, ram, rf, ok);
        if (!ok) fail_wait();
        chk({22'h0, ram, rf, wr ? 8'h00 : rd}, {22'h0, ef, wr ? 8'h00 : er});
    endtask
    task automatic launch();
        wreg(`NVM_CTRL_OFF, 32'h52, `RESP_OKAY);
        wreg(`NVM_CTRL_OFF, 32'hA2, `RESP_OKAY);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        if (irq !== 1'b1) fail_wait();
        rreg(`NVM_CTRL_OFF, 32'h2, `RESP_OKAY);
        rreg(`IRQ_STATUS_OFF, 32'h1, `RESP_OKAY);
        wreg(`IRQ_STATUS_OFF, 32'h1, `RESP_OKAY);
    endtask
    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rreg(`NVM_CTRL_OFF, 32'h0, `RESP_OKAY);
        rreg(`IRQ_STATUS_OFF, 32'h0, `RESP_OKAY);
        rreg(`IRQ_MASK_OFF, 32'h0, `RESP_OKAY);
        rreg(12'h00C, 32'h0, `RESP_SLVERR);
        wreg(12'h010, 32'h2, `RESP_SLVERR);
        xd(1'b0, 16'h0010, 8'h00, 8'h00, 2'b10);
        xd(1'b1, 16'h0305, 8'h77, 8'h00, 2'b10);
        wreg(`IRQ_MASK_OFF, 32'h1, `RESP_OKAY);
        wreg(`NVM_CTRL_OFF, 32'h2, `RESP_OKAY);
        rreg(`NVM_CTRL_OFF, 32'h2, `RESP_OKAY);
        xd(1'b0, 16'h0800, 8'h00, 8'h00, 2'b10);
        xd(1'b0, 16'h0185, 8'h00, `ERASED_BYTE, 2'b00);
        for (int i = 0; i < 4; i++) xd(1'b1, la[i], ld[i], 8'h00, 2'b00);
        launch();
        rreg(`NVM_CTRL_OFF, 32'h3, `RESP_OKAY);
        xd(1'b0, 16'h0180, 8'h00, `REFUSED_BYTE, 2'b01);
        xd(1'b1, 16'h0181, 8'h99, 8'h00, 2'b01);
        wait_irq();
        for (int i = 0; i < 4; i++) xd(1'b0, la[i], 8'h00, le[i], 2'b00);
        xd(1'b0, 16'h0181, 8'h00, `ERASED_BYTE, 2'b00);
        xd(1'b0, 16'h0305, 8'h00, `ERASED_BYTE, 2'b00);
        rreg(`IRQ_STATUS_OFF, 32'h0, `RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        xd(1'b1, 16'h0280, 8'h33, 8'h00, 2'b00);
        launch();
        wait_irq();
        xd(1'b0, 16'h0280, 8'h00, 8'h33, 2'b00);
        xd(1'b0, 16'h02FF, 8'h00, `ERASED_BYTE, 2'b00);
        xd(1'b0, 16'h0285, 8'h00, `ERASED_BYTE, 2'b00);
        // Three ways to break the launch pair: other instruction, data move, bus write
        for (int k = 0; k < 3; k++) begin
            wreg(`NVM_CTRL_OFF, 32'h52, `RESP_OKAY);
            if (k == 0) cpu_u.step();
            else if (k == 1) xd(1'b1, 16'h0302, 8'h44, 8'h00, 2'b00);
            else wreg(`IRQ_MASK_OFF, 32'h3, `RESP_OKAY);
            wreg(`NVM_CTRL_OFF, 32'hA2, `RESP_OKAY);
            rreg(`NVM_CTRL_OFF, 32'h2, `RESP_OKAY);
            rreg(`IRQ_STATUS_OFF, 32'h2, `RESP_OKAY);
            chk({31'h0, irq}, {31'h0, k == 2});
            wreg(`IRQ_STATUS_OFF, 32'h2, `RESP_OKAY);
        end
        rreg(`IRQ_STATUS_OFF, 32'h0, `RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        xd(1'b0, 16'h0302, 8'h00, `ERASED_BYTE, 2'b00);
        launch();
        wait_irq();
        xd(1'b0, 16'h0302, 8'h00, 8'h44, 2'b00);
        give_verdict();
    end
endmodule
